/* File: pkg/serial_port_pkg.sv */
// constants shared by the serial port register block
// assumes a byte-wide register port clocked by clock_i
package serial_port_pkg;
    // register offsets
    localparam logic [7:0] CONTROL_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h11;
    localparam logic [7:0] DATA_ADDR = 8'h12;
    // control register fields
    localparam int RX_IRQ_EN_BIT = 7;
    localparam int MASTER_SEL_BIT = 5;
    localparam int POLARITY_BIT = 3;
    localparam int PHASE_BIT = 2;
    localparam int OPEN_DRAIN_BIT = 1;
    localparam int ENABLE_BIT = 0;
    localparam int TX_IRQ_EN_BIT = 6;
    // status/control register fields
    localparam int RX_FULL_BIT = 7;
    localparam int ERR_IRQ_EN_BIT = 6;
    localparam int OVERRUN_BIT = 5;
    localparam int FAULT_BIT = 4;
    localparam int TX_EMPTY_BIT = 3;
    localparam int FAULT_DETECT_BIT = 2;
    localparam int RATE_HIGH_BIT = 1;
    localparam int RATE_LOW_BIT = 0;
    // reset values: master and phase set in control, transmit empty set in status, the rest clear
    localparam logic [7:0] CONTROL_RESET = 8'h24;
    localparam logic [7:0] STATUS_RESET = 8'h08;
    localparam logic [7:0] WRITABLE_STATUS_MASK = 8'h47;
    // rate divisors for codes 00..11
    localparam logic [7:0] DIV_CODE0 = 8'h02;
    localparam logic [7:0] DIV_CODE1 = 8'h08;
    localparam logic [7:0] DIV_CODE2 = 8'h20;
    localparam logic [7:0] DIV_CODE3 = 8'h80;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    typedef enum logic [1:0] {IDLE, LOADED, SHIFTING} xfer_state_t;
endpackage

/* File: core/serial_port.sv */
// byte-wide serial port, master or slave, with three byte registers
// assumes pins are synchronous to clock_i and the base clock equals clock_i
`timescale 1ns/1ps
`default_nettype none
module serial_port
    import serial_port_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // serial pins
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_n_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_n_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_n_o,
    input wire logic select_n_i,
    // interrupt requests
    output logic irq_o
);
    import serial_port_pkg::*;

    // ==========================================================
    // registers
    logic [7:0] control;
    logic [7:0] status_ctl;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] shifter;
    logic [7:0] div_cnt;
    logic [3:0] bit_cnt;
    logic sclk_q;
    logic sclk_prev;
    logic sel_prev;
    logic samp;
    logic ovr_armed;
    logic rxf_armed;
    logic flt_armed;
    xfer_state_t state;

    // ==========================================================
    // decode
    wire ctl_wr = wr_i && addr_i == CONTROL_ADDR;
    wire sts_wr = wr_i && addr_i == STATUS_ADDR;
    wire dat_wr = wr_i && addr_i == DATA_ADDR;
    wire sts_rd = rd_i && addr_i == STATUS_ADDR;
    wire dat_rd = rd_i && addr_i == DATA_ADDR;
    wire enabled = control[ENABLE_BIT];
    wire is_master = control[MASTER_SEL_BIT];
    wire clock_polarity = control[POLARITY_BIT];
    wire clock_phase = control[PHASE_BIT];
    wire wired_or = control[OPEN_DRAIN_BIT];
    wire fault_en = status_ctl[FAULT_DETECT_BIT];
    wire [1:0] rate = {status_ctl[RATE_HIGH_BIT], status_ctl[RATE_LOW_BIT]};
    // master divisor, ignored in slave mode
    wire [7:0] divisor = rate == 2'b00 ? DIV_CODE0 : rate == 2'b01 ? DIV_CODE1 :
                         rate == 2'b10 ? DIV_CODE2 : DIV_CODE3;
    wire half_tick = div_cnt == divisor - 8'h01;
    // slave view of the link
    wire selected = !select_n_i;
    wire sel_fall = sel_prev && !select_n_i;
    wire sel_rise = !sel_prev && select_n_i;
    wire sclk_edge = sclk_i != sclk_prev;
    // leading edge moves away from idle level
    wire lead_edge = sclk_edge && (sclk_i != clock_polarity);
    wire slave_mode = enabled && !is_master;
    wire master_mode = enabled && is_master;
    // slave edges only count while selected
    wire s_edge = slave_mode && selected && sclk_edge;
    wire m_edge = master_mode && state == SHIFTING && half_tick;
    wire any_edge = s_edge || m_edge;
    wire is_lead = s_edge ? lead_edge : (sclk_q == clock_polarity);
    // sample on leading edge when phase 0, trailing when phase 1
    wire sample_now = any_edge && (is_lead != clock_phase);
    // phase 1 already shows the msb before the first leading edge, so no shift there
    wire first_lead = clock_phase && bit_cnt == '0;
    wire shift_now = any_edge && (is_lead == clock_phase) && !first_lead;
    wire last_bit = bit_cnt == BITS_PER_BYTE;
    // a byte ends the cycle after its eighth sample; a phase-1 slave sees no ninth edge
    wire byte_done = state == SHIFTING && last_bit;
    wire tx_empty = status_ctl[TX_EMPTY_BIT];
    wire rx_full = status_ctl[RX_FULL_BIT];
    // loading the shifter from the transmit buffer
    wire start_slave0 = slave_mode && !clock_phase && sel_fall && state == LOADED;
    wire start_slave1 = slave_mode && clock_phase && selected && state == LOADED
                        && s_edge && lead_edge;
    wire take_tx = enabled && !tx_empty && (state == IDLE);
    wire fin = byte_done;
    wire mfault = fault_en && ((master_mode && selected) ||
                  (slave_mode && sel_rise && state == SHIFTING));

    // ==========================================================
    // control register
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            control <= CONTROL_RESET;
        end else if (ctl_wr) begin
            control <= wdata_i;
        end else if (master_mode && mfault) begin
            control[ENABLE_BIT] <= 1'b0;
        end
    end

    // ==========================================================
    // status flags; a set in the same cycle beats a clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_ctl <= STATUS_RESET;
            ovr_armed <= 1'b0;
            rxf_armed <= 1'b0;
            flt_armed <= 1'b0;
        end else begin
            if (sts_wr) begin
                status_ctl[ERR_IRQ_EN_BIT] <= wdata_i[ERR_IRQ_EN_BIT];
                status_ctl[FAULT_DETECT_BIT] <= wdata_i[FAULT_DETECT_BIT];
                status_ctl[RATE_HIGH_BIT] <= wdata_i[RATE_HIGH_BIT];
                status_ctl[RATE_LOW_BIT] <= wdata_i[RATE_LOW_BIT];
            end
            if (sts_rd) begin
                ovr_armed <= status_ctl[OVERRUN_BIT];
                flt_armed <= status_ctl[FAULT_BIT];
                rxf_armed <= rx_full;
            end
            if (fin && !rx_full) begin
                status_ctl[RX_FULL_BIT] <= 1'b1;
            end else if (dat_rd) begin
                status_ctl[RX_FULL_BIT] <= 1'b0;
            end
            if (fin && rx_full) begin
                status_ctl[OVERRUN_BIT] <= 1'b1;
            end else if (dat_rd && ovr_armed) begin
                status_ctl[OVERRUN_BIT] <= 1'b0;
                ovr_armed <= 1'b0;
            end
            if (mfault) begin
                status_ctl[FAULT_BIT] <= 1'b1;
            end else if (dat_wr && flt_armed) begin
                status_ctl[FAULT_BIT] <= 1'b0;
                flt_armed <= 1'b0;
            end
            if (take_tx || !enabled) begin
                status_ctl[TX_EMPTY_BIT] <= 1'b1;
            end else if (dat_wr) begin
                status_ctl[TX_EMPTY_BIT] <= 1'b0;
            end
        end
    end

    // ==========================================================
    // data buffers
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_buf <= ZERO_BYTE;
            rx_buf <= ZERO_BYTE;
        end else begin
            if (dat_wr) begin
                tx_buf <= wdata_i;
            end
            // old byte kept on overrun
            if (fin && !rx_full) begin
                rx_buf <= {shifter[6:0], samp};
            end
        end
    end

    // ==========================================================
    // transfer engine
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= IDLE;
            shifter <= ZERO_BYTE;
            bit_cnt <= 4'h0;
            div_cnt <= ZERO_BYTE;
            sclk_q <= 1'b0;
            sclk_prev <= 1'b0;
            sel_prev <= 1'b1;
            samp <= 1'b0;
        end else begin
            sclk_prev <= sclk_i;
            sel_prev <= select_n_i;
            div_cnt <= (state == SHIFTING && !half_tick) ? div_cnt + 8'h01 : ZERO_BYTE;
            if (!enabled) begin
                // partial reset: stop the byte, transmit empty set, other flags left alone
                state <= IDLE;
                bit_cnt <= 4'h0;
                sclk_q <= clock_polarity;
            end else begin
                unique case (state)
                    IDLE: begin
                        sclk_q <= clock_polarity;
                        if (take_tx) begin
                            shifter <= tx_buf;
                            state <= is_master ? SHIFTING : LOADED;
                            bit_cnt <= 4'h0;
                        end
                    end
                    LOADED: begin
                        if (start_slave0 || start_slave1) begin
                            state <= SHIFTING;
                        end
                    end
                    SHIFTING: begin
                        if (m_edge) begin
                            sclk_q <= ~sclk_q;
                        end
                        if (sample_now) begin
                            samp <= is_master ? miso_i : mosi_i;
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (fin) begin
                            state <= IDLE;
                            sclk_q <= clock_polarity;
                        end else if (shift_now) begin
                            shifter <= {shifter[6:0], samp};
                        end
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // pins; open drain drives low only
    wire mosi_bit = shifter[7];
    wire slave_drive = slave_mode && selected;
    assign sclk_o = wired_or ? 1'b0 : sclk_q;
    assign sclk_oe_n_o = !(master_mode && (!wired_or || !sclk_q));
    assign mosi_o = wired_or ? 1'b0 : mosi_bit;
    assign mosi_oe_n_o = !(master_mode && (!wired_or || !mosi_bit));
    assign miso_o = wired_or ? 1'b0 : mosi_bit;
    assign miso_oe_n_o = !(slave_drive && (!wired_or || !mosi_bit));

    // interrupt requests
    wire rx_req = control[RX_IRQ_EN_BIT] && rx_full;
    wire tx_req = control[TX_IRQ_EN_BIT] && tx_empty;
    wire err_req = status_ctl[ERR_IRQ_EN_BIT] &&
                   (status_ctl[FAULT_BIT] || status_ctl[OVERRUN_BIT]);
    assign irq_o = rx_req || tx_req || err_req;

    // read data, one cycle after the strobe
    wire [7:0] rd_mux = addr_i == CONTROL_ADDR ? control :
                        addr_i == STATUS_ADDR ? status_ctl :
                        addr_i == DATA_ADDR ? rx_buf : ZERO_BYTE;
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= ZERO_BYTE;
        end else begin
            rdata_o <= rd_i ? rd_mux : ZERO_BYTE;
        end
    end

    // ==========================================================
    // checks
    a_rx_full_irq: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (control[RX_IRQ_EN_BIT] && rx_full) |-> irq_o) else $error("rx irq missing");
    a_tx_irq_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (control[TX_IRQ_EN_BIT] && tx_empty) |-> irq_o) else $error("tx irq missing");
    a_err_irq_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (status_ctl[ERR_IRQ_EN_BIT] && status_ctl[OVERRUN_BIT]) |-> irq_o)
        else $error("err irq missing");
    a_data_rd_clr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (dat_rd && !fin) |=> !rx_full) else $error("rx full not cleared");
    a_rx_sets: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        fin |=> rx_full) else $error("rx full not set");
    a_ovr_keep: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (fin && rx_full) |=> (status_ctl[OVERRUN_BIT] && rx_buf == $past(rx_buf)))
        else $error("overrun lost old byte");
    a_idle_handoff: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (dat_wr && state == IDLE && enabled) |-> ##[1:2] tx_empty)
        else $error("tx empty late");
    a_sel_high_float: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        select_n_i |-> miso_oe_n_o) else $error("miso driven while deselected");
    a_fault_sticky: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (status_ctl[FAULT_BIT] && !dat_wr) |=> status_ctl[FAULT_BIT])
        else $error("fault dropped");
    a_no_arm_keep: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (status_ctl[OVERRUN_BIT] && !ovr_armed) |=> status_ctl[OVERRUN_BIT])
        else $error("overrun cleared without arm");

    // ==========================================================
    // transfer steps
    sequence s_master_take;
        master_mode && state == IDLE && take_tx;
    endsequence
    sequence s_slave_take;
        slave_mode && state == IDLE && take_tx;
    endsequence
    a_master_starts: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_master_take |=> state == SHIFTING)
        else $error("master did not start");
    a_slave_waits: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_slave_take |=> state == LOADED)
        else $error("slave did not load");
    a_phase0_start: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (slave_mode && !clock_phase && state == LOADED && sel_fall) |=> state == SHIFTING)
        else $error("phase 0 slave did not start");
    a_phase1_start: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        start_slave1 |=> state == SHIFTING)
        else $error("phase 1 slave did not start");
    a_phase1_wait: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (slave_mode && clock_phase && state == LOADED && !s_edge) |=> state == LOADED)
        else $error("phase 1 slave started early");
    a_deselect_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (slave_mode && !selected && state == SHIFTING && !fin) |=> state == SHIFTING)
        else $error("select high moved the state");
    a_deselect_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (slave_mode && !selected && state == LOADED) |=> state == LOADED)
        else $error("deselected slave started");
    a_busy_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (slave_mode && state != IDLE && dat_wr) |=> !tx_empty)
        else $error("busy slave took a byte");
    a_disable_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !enabled |=> state == IDLE)
        else $error("disabled port kept shifting");
    a_master_fault_off: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (master_mode && mfault && !ctl_wr) |=> !enabled)
        else $error("faulted master stayed on");
    a_idle_clock: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (master_mode && state == IDLE) |=> sclk_q == $past(clock_polarity))
        else $error("idle clock level wrong");
    a_tx_empty_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        take_tx |=> tx_empty)
        else $error("tx empty not set on handoff");
    a_tx_buf_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        dat_wr |=> tx_buf == $past(wdata_i))
        else $error("transmit buffer not written");
    a_rx_buf_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !fin |=> rx_buf == $past(rx_buf))
        else $error("receive buffer changed");
    a_rx_two_step: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (rxf_armed && dat_rd && !fin) |=> !rx_full)
        else $error("rx full survived clear");
    a_ovr_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (ovr_armed && dat_rd && !fin) |=> !status_ctl[OVERRUN_BIT])
        else $error("overrun not cleared");
    a_fault_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (flt_armed && dat_wr && !mfault) |=> !status_ctl[FAULT_BIT])
        else $error("fault not cleared");
    a_fault_gated: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (!fault_en && !status_ctl[FAULT_BIT]) |=> !status_ctl[FAULT_BIT])
        else $error("fault set while detection off");
    a_open_drain_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wired_or |-> !(sclk_o || mosi_o || miso_o))
        else $error("open drain pin driven high");
    a_irq_quiet: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        (!rx_req && !tx_req && !err_req) |-> !irq_o)
        else $error("request without cause");
endmodule
`default_nettype wire

/* File: bench/remote_serial_model.sv */
// remote serial party: master toward a slave port, slave toward a master port
// assumes pins are sampled on clock_i; clock polarity 0, clock phase 1
`timescale 1ns/1ps
`default_nettype none
module remote_serial_model (
    // control from the bench
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic [7:0] send_i,
    input wire logic port_master_i,
    // resolved pin levels
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    // pins driven by the remote party
    output logic sclk_o,
    output logic mosi_o,
    output logic select_n_o,
    output logic miso_o = 1'b0,
    // results
    output logic [7:0] got_o,
    output logic [7:0] heard_o = 8'h00,
    output logic done_o
);
    // arbitrary reply byte of the remote slave
    localparam logic [7:0] REPLY = 8'h3c;
    logic sclk_q = 1'b0;
    logic [2:0] idx = 3'h7;
    // ==========================================
    // remote master: slow clock, idle low, flips mosi once after each frame
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        select_n_o = 1'b1;
        done_o = 1'b0;
        got_o = 8'h00;
        forever begin
            @(posedge clock_i);
            if (start_i) begin
                done_o <= 1'b0;
                select_n_o <= 1'b0;
                repeat (4) @(posedge clock_i);
                for (int i = 7; i >= 0; i--) begin
                    sclk_o <= 1'b1;
                    mosi_o <= send_i[i];
                    repeat (4) @(posedge clock_i);
                    sclk_o <= 1'b0;
                    got_o[i] <= miso_i;
                    repeat (4) @(posedge clock_i);
                end
                select_n_o <= 1'b1;
                mosi_o <= ~mosi_o;
                done_o <= 1'b1;
            end
        end
    end
    // ==========================================
    // remote slave: shifts on the leading edge, listens on the trailing one
    always @(posedge clock_i) begin
        sclk_q <= sclk_i;
        if (!port_master_i) begin
            miso_o <= ~miso_o;
            idx <= 3'h7;
        end else if (sclk_i && !sclk_q) begin
            miso_o <= REPLY[idx];
            idx <= idx - 3'h1;
        end else if (!sclk_i && sclk_q) begin
            heard_o <= {heard_o[6:0], mosi_i};
        end
    end
endmodule
`default_nettype wire

/* File: bench/test_serial_port.sv */
// self-checking bench for the serial port register block
// assumes the remote model on the pins and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_serial_port;
    import serial_port_pkg::*;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic irq;} row_t;
    logic clock_i, sys_rst_i, wr_i, rd_i, start, sel_low;
    logic [7:0] addr_i, wdata_i, send, v, rdata_o, got, heard;
    logic sclk_o, sclk_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, irq_o;
    logic p_sclk, p_mosi, p_sel, p_miso, done, s_w, mo_w, mi_w;
    int errors = 0;
    int total_checks = 0;
    int h, l;
    row_t rows [0:8] = '{'{0, CONTROL_ADDR, CONTROL_RESET, 0}, '{0, STATUS_ADDR, 8'h08, 0},
        '{0, 8'h13, 8'h00, 0}, '{1, STATUS_ADDR, 8'hff, 0}, '{0, STATUS_ADDR, 8'h4f, 0},
        '{1, STATUS_ADDR, 8'h00, 0}, '{1, CONTROL_ADDR, 8'hee, 1},
        '{0, CONTROL_ADDR, 8'hee, 1}, '{1, CONTROL_ADDR, 8'h24, 0}};
    // a released pin follows whoever still drives it
    assign s_w = sclk_oe_n_o ? p_sclk : sclk_o;
    assign mo_w = mosi_oe_n_o ? p_mosi : mosi_o;
    assign mi_w = miso_oe_n_o ? p_miso : miso_o;
    serial_port DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_i(s_w),
        .sclk_o(sclk_o), .sclk_oe_n_o(sclk_oe_n_o), .mosi_i(mo_w), .mosi_o(mosi_o),
        .mosi_oe_n_o(mosi_oe_n_o), .miso_i(mi_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
        .select_n_i(p_sel & ~sel_low), .irq_o(irq_o));
    remote_serial_model remote (.clock_i(clock_i), .start_i(start), .send_i(send),
        .port_master_i(~sclk_oe_n_o), .sclk_i(s_w), .mosi_i(mo_w), .miso_i(mi_w),
        .sclk_o(p_sclk), .mosi_o(p_mosi), .select_n_o(p_sel), .miso_o(p_miso),
        .got_o(got), .heard_o(heard), .done_o(done));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // ==========================================
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic timeout();
        errors++;
        $display("CHECK FAILED wait expected done seen timeout");
        print_verdict();
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic poll(input int b);
        for (int n = 0; n < 300; n++) begin
            rd(STATUS_ADDR, v);
            if (v[b] === 1'b1) return;
        end
        timeout();
    endtask
    task automatic wait_lvl(input logic lv, output int n);
        n = 0;
        while (s_w !== lv) begin
            if (n > 2000) timeout();
            n++;
            @(posedge clock_i);
            #1;
        end
    endtask
    task automatic frame(input logic [7:0] b);
        @(posedge clock_i);
        send <= b;
        start <= 1'b1;
        @(posedge clock_i);
        start <= 1'b0;
        repeat (2) @(posedge clock_i);
        for (int n = 0; done !== 1'b1; n++) begin
            if (n > 400) timeout();
            @(posedge clock_i);
        end
    endtask
    // ==========================================
    initial begin
        sys_rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        start = 1'b0;
        send = 8'h00;
        sel_low = 1'b0;
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) wr(rows[i].addr, rows[i].data);
            else rd(rows[i].addr, v);
            if (!rows[i].wr) check("register", rows[i].data, v);
            #1 check("irq", {7'h00, rows[i].irq}, {7'h00, irq_o});
        end
        // master byte with the fastest rate
        wr(CONTROL_ADDR, 8'h25);
        check("idle clock", 8'h00, {7'h00, s_w});
        wr(DATA_ADDR, 8'ha5);
        rd(STATUS_ADDR, v);
        check("tx empty", 8'h01, {7'h00, v[TX_EMPTY_BIT]});
        wait_lvl(1'b0, h);
        wait_lvl(1'b1, h);
        wait_lvl(1'b0, h);
        wait_lvl(1'b1, l);
        check("clock period", {DIV_CODE0[6:0], 1'b0}, 8'(h + l));
        poll(RX_FULL_BIT);
        rd(DATA_ADDR, v);
        check("master rx", 8'h3c, v);
        check("remote heard", 8'ha5, heard);
        rd(STATUS_ADDR, v);
        check("rx full clear", 8'h00, v & 8'h80);
        // slave bytes, the first one still unread when the second arrives
        wr(CONTROL_ADDR, 8'h05);
        #1 check("miso released", 8'h01, {7'h00, miso_oe_n_o});
        wr(DATA_ADDR, 8'h96);
        frame(8'h5a);
        check("slave tx", 8'h96, got);
        wr(DATA_ADDR, 8'h69);
        frame(8'hc3);
        check("slave tx 2", 8'h69, got);
        rd(DATA_ADDR, v);
        check("old byte kept", 8'h5a, v);
        rd(STATUS_ADDR, v);
        check("overrun held", 8'h20, v & 8'ha0);
        rd(DATA_ADDR, v);
        rd(STATUS_ADDR, v);
        check("overrun clear", 8'h00, v & 8'h20);
        // master sees its select pulled low
        wr(CONTROL_ADDR, 8'h27);
        #1 check("open drain clock", 8'h00, {6'h00, sclk_o, sclk_oe_n_o});
        wr(STATUS_ADDR, 8'h04);
        @(posedge clock_i);
        sel_low <= 1'b1;
        repeat (3) @(posedge clock_i);
        sel_low <= 1'b0;
        wr(STATUS_ADDR, 8'h40);
        wr(DATA_ADDR, 8'h00);
        rd(CONTROL_ADDR, v);
        check("master disabled", 8'h00, v & 8'h01);
        rd(STATUS_ADDR, v);
        check("fault held", 8'h10, v & 8'h10);
        check("error irq", 8'h01, {7'h00, irq_o});
        wr(DATA_ADDR, 8'h00);
        rd(STATUS_ADDR, v);
        check("fault clear", 8'h00, v & 8'h10);
        // second reset in mid-run
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(STATUS_ADDR, v);
        check("status after reset", 8'h08, v);
        print_verdict();
    end
endmodule
`default_nettype wire
